/* File: hw/tsrb_defines.vh */
// Constants for the tile status register bank: numbers, fields, masks.
// Overview of operation
// - Boot status at 0x03, tile number 23:16
// - Boot status 1:0 show sampled clock straps
// - Bit 2 JTAG boot, bit 3 RAM boot
// - Bit 5 reports second core powered off
// - Bit 4 skips OTP read-level polling
// - Security register 0x05 loaded from OTP word
// - Security bit 31 refuses further writes
// - Security bit 14 blocks global debug
// - Bit 12 locks all sectors, 11:8 each
// - Bit 4 denies JTAG clock/boot config access
// - Bit 0 blocks JTAG debug TAP
// - Four oscillator counters, control at 0x06
// - Control bit 1 core, bit 0 periph, reset 0
// - Oscillators asynchronous, counts give random bits
// - Counts 16-bit in 15:0, survive system reset
// - Counts at 0x07, 0x08, 0x09, 0x0A
// - RAM size in bytes at 0x0C, 31:2
// - Debug entry captures status word into 0x10
// - Status bits 0..4: events, irq, enb, int, kernel
// - Status bit 7 fast issue, bit 6 paused
// - Debug entry captures PC 0x11, SP 0x12
// - Reached by status reads/writes with number
`ifndef TSRB_DEFINES_VH
`define TSRB_DEFINES_VH

// Register numbers
`define TSRB_NUM_BOOT_STATUS     8'h03
`define TSRB_NUM_SECURITY        8'h05
`define TSRB_NUM_OSC_CONTROL     8'h06
`define TSRB_NUM_OSC_COUNT0      8'h07
`define TSRB_NUM_OSC_COUNT1      8'h08
`define TSRB_NUM_OSC_COUNT2      8'h09
`define TSRB_NUM_OSC_COUNT3      8'h0A
`define TSRB_NUM_MEMORY_CAPACITY 8'h0C
`define TSRB_NUM_DBG_STATUS      8'h10
`define TSRB_NUM_DBG_PC          8'h11
`define TSRB_NUM_DBG_SP          8'h12

// Boot status fields
`define TSRB_BOOT_PROC_HI        23
`define TSRB_BOOT_PROC_LO        16
`define TSRB_BOOT_SECURE_BIT     8
`define TSRB_BOOT_CORE1_OFF_BIT  5
`define TSRB_BOOT_NO_POLL_BIT    4
`define TSRB_BOOT_FROM_RAM_BIT   3
`define TSRB_BOOT_FROM_JTAG_BIT  2
`define TSRB_BOOT_STRAP_HI       1
`define TSRB_BOOT_STRAP_LO       0

// Security fields
`define TSRB_SEC_WRITE_LOCK_BIT  31
`define TSRB_SEC_GLOBAL_DBG_BIT  14
`define TSRB_SEC_MASTER_LOCK_BIT 12
`define TSRB_SEC_SECTOR_HI       11
`define TSRB_SEC_SECTOR_LO       8
`define TSRB_SEC_REDUNDANCY_BIT  7
`define TSRB_SEC_SECURE_BOOT_BIT 5
`define TSRB_SEC_JTAG_CFG_BIT    4
`define TSRB_SEC_JTAG_TAP_BIT    0
`define TSRB_SEC_MASK            32'h80005FB1
`define TSRB_SEC_RESET           32'h00000000

// Oscillator control fields
`define TSRB_OSC_CORE_BIT        1
`define TSRB_OSC_PERIPH_BIT      0
`define TSRB_OSC_CTRL_RESET      2'h0

// Saved status word: writable bits, 8 and 5 read only
`define TSRB_STAT_WRITE_MASK     32'h000006DF
`define TSRB_STAT_CAPTURE_MASK   32'h000007DF
`define TSRB_MEM_CAP_MASK        32'hFFFFFFFC
`define TSRB_WORD_ZERO           32'h00000000

`endif

/* File: hw/tsrb_osc_counter.v */
// One ring oscillator counter, cleared only by power-on reset.
`timescale 1ns/1ps
module tsrb_osc_counter #(
    parameter WIDTH = 16
) (
    input  wire             mclk,      // Tile clock
    input  wire             porReset,  // Power-on reset, high
    input  wire             run,       // Oscillator enable
    input  wire             tick,      // One pulse per oscillator period
    output wire [WIDTH-1:0] count      // Current count
);

    reg  [WIDTH-1:0] count_reg;
    wire [WIDTH-1:0] count_next;

    // Wraps naturally at full width
    assign count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};

    // System reset is not wired here so counts survive it
    always @(posedge mclk or posedge porReset) begin
        if (porReset) begin
            count_reg <= {WIDTH{1'b0}};
        end else if (run && tick) begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule // tsrb_osc_counter

/* File: hw/tsrb_status_bank.v */
// Processor status register bank for one tile.
`timescale 1ns/1ps
`include "tsrb_defines.vh"
module tsrb_status_bank #(
    parameter RAM_BYTES = 32'h00040000, // RAM size reported
    parameter OSC_WIDTH = 16,           // Oscillator counter width
    parameter OSC_COUNT = 4             // Number of oscillators
) (
    input  wire                 mclk,              // Core clock, 100 MHz
    input  wire                 reset,             // System reset, high
    input  wire                 porReset,          // Power-on reset, high
    input  wire                 psValid,           // Status access strobe
    input  wire                 psWrite,           // 1 write, 0 read
    input  wire [7:0]           psNum,             // Register number
    input  wire [31:0]          psWdata,           // Write data
    input  wire                 inDebugMode,       // Debug privilege held
    output reg  [31:0]          psRdata,           // Read data
    output reg                  psAck,             // Access answered
    output reg                  psErr,             // Unmapped or refused
    input  wire [7:0]           processorNumber,   // Tile number
    input  wire [1:0]           clockMultStrapPins,// Clock mult straps
    input  wire                 bootFromJtag,      // Strap: JTAG boot
    input  wire                 bootFromRam,       // Strap: RAM boot
    input  wire                 otpPollSkip,       // Strap: skip OTP poll
    input  wire                 secondCorePoweredOff, // Core 1 off
    input  wire                 secureBootOverride,// Overwrite boot mode
    input  wire                 otpWordValid,      // OTP word load pulse
    input  wire [31:0]          otpSecurityWord,   // Word from OTP
    input  wire [OSC_COUNT-1:0] oscTick,           // Oscillator periods
    input  wire                 debugEntry,        // Debugger entry pulse
    input  wire [31:0]          threadStatus,      // Live status word
    input  wire [31:0]          threadPc,          // Live PC
    input  wire [31:0]          threadSp,          // Live SP
    output wire                 coreOscRun,        // Core osc enable
    output wire                 periphOscRun,      // Periph osc enable
    output wire                 globalDebugBlocked,// Global debug off
    output wire                 jtagBootCfgDenied, // JTAG cfg denied
    output wire                 jtagTapBlocked,    // JTAG TAP blocked
    output wire                 otpMasterLock,     // All sectors locked
    output wire [3:0]           otpSectorLock,     // Per sector lock
    output wire                 otpRedundancyOn,   // OTP redundancy
    output wire                 secureBootFromOtp  // Boot from OTP
);

    ////////////////////////////////////////////////////////////////////////
    // Strap capture

    reg        strapTaken_reg;
    reg [7:0]  procNum_reg;
    reg [1:0]  strapMult_reg;
    reg        bootJtag_reg;
    reg        bootRam_reg;
    reg        noPoll_reg;
    reg        core1Off_reg;
    reg        secureBoot_reg;

    // Straps caught on the first edge after release, never under reset
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            strapTaken_reg <= 1'b0;
            procNum_reg    <= 8'h00;
            strapMult_reg  <= 2'h0;
            bootJtag_reg   <= 1'b0;
            bootRam_reg    <= 1'b0;
            noPoll_reg     <= 1'b0;
            core1Off_reg   <= 1'b0;
            secureBoot_reg <= 1'b0;
        end else if (!strapTaken_reg) begin
            strapTaken_reg <= 1'b1;
            procNum_reg    <= processorNumber;
            strapMult_reg  <= clockMultStrapPins;
            bootJtag_reg   <= bootFromJtag;
            bootRam_reg    <= bootFromRam;
            noPoll_reg     <= otpPollSkip;
            core1Off_reg   <= secondCorePoweredOff;
            secureBoot_reg <= secureBootOverride;
        end
    end

    reg [31:0] bootWord;

    // Assemble the read-only boot status word
    always @* begin
        bootWord = `TSRB_WORD_ZERO;
        bootWord[`TSRB_BOOT_PROC_HI:`TSRB_BOOT_PROC_LO]   = procNum_reg;
        bootWord[`TSRB_BOOT_STRAP_HI:`TSRB_BOOT_STRAP_LO] = strapMult_reg;
        bootWord[`TSRB_BOOT_FROM_JTAG_BIT] = bootJtag_reg;
        bootWord[`TSRB_BOOT_FROM_RAM_BIT]  = bootRam_reg;
        bootWord[`TSRB_BOOT_NO_POLL_BIT]   = noPoll_reg;
        bootWord[`TSRB_BOOT_CORE1_OFF_BIT] = core1Off_reg;
        bootWord[`TSRB_BOOT_SECURE_BIT]    = secureBoot_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Access decode

    wire wrStrobe;
    wire rdStrobe;
    wire hitSecurity;
    wire hitOscCtrl;
    wire hitDbgStatus;
    wire hitDbgPc;
    wire hitDbgSp;
    wire secLocked;

    // Accesses come from the tile processor with a register number
    assign wrStrobe     = psValid && psWrite;
    assign rdStrobe     = psValid && !psWrite;
    assign hitSecurity  = (psNum == `TSRB_NUM_SECURITY);
    assign hitOscCtrl   = (psNum == `TSRB_NUM_OSC_CONTROL);
    assign hitDbgStatus = (psNum == `TSRB_NUM_DBG_STATUS);
    assign hitDbgPc     = (psNum == `TSRB_NUM_DBG_PC);
    assign hitDbgSp     = (psNum == `TSRB_NUM_DBG_SP);

    ////////////////////////////////////////////////////////////////////////
    // Security configuration

    reg  [31:0] security_reg;
    wire [31:0] secWriteData;

    assign secLocked    = security_reg[`TSRB_SEC_WRITE_LOCK_BIT];
    assign secWriteData = psWdata & `TSRB_SEC_MASK;

    // OTP load has priority; a set lock bit freezes software writes
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            security_reg <= `TSRB_SEC_RESET;
        end else if (otpWordValid) begin
            security_reg <= otpSecurityWord & `TSRB_SEC_MASK;
        end else if (wrStrobe && hitSecurity && !secLocked) begin
            security_reg <= secWriteData;
        end
    end

    // Policy outputs straight from the stored word
    assign globalDebugBlocked = security_reg[`TSRB_SEC_GLOBAL_DBG_BIT];
    assign otpMasterLock      = security_reg[`TSRB_SEC_MASTER_LOCK_BIT];
    assign otpSectorLock      = security_reg[`TSRB_SEC_SECTOR_HI:`TSRB_SEC_SECTOR_LO]
                                | {4{security_reg[`TSRB_SEC_MASTER_LOCK_BIT]}};
    assign jtagBootCfgDenied  = security_reg[`TSRB_SEC_JTAG_CFG_BIT];
    assign jtagTapBlocked     = security_reg[`TSRB_SEC_JTAG_TAP_BIT];
    assign otpRedundancyOn    = security_reg[`TSRB_SEC_REDUNDANCY_BIT];
    assign secureBootFromOtp  = security_reg[`TSRB_SEC_SECURE_BOOT_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Oscillator control and counters

    reg  [1:0] oscCtrl_reg;
    wire [1:0] oscCtrl_next;

    assign oscCtrl_next = {psWdata[`TSRB_OSC_CORE_BIT], psWdata[`TSRB_OSC_PERIPH_BIT]};

    // Both enables clear on system reset
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            oscCtrl_reg <= `TSRB_OSC_CTRL_RESET;
        end else if (wrStrobe && hitOscCtrl) begin
            oscCtrl_reg <= oscCtrl_next;
        end
    end

    assign coreOscRun   = oscCtrl_reg[`TSRB_OSC_CORE_BIT];
    assign periphOscRun = oscCtrl_reg[`TSRB_OSC_PERIPH_BIT];

    wire [OSC_WIDTH-1:0] oscCount [0:OSC_COUNT-1];

    // First half of the oscillators sit on the core side
    genvar gi;
    generate
        for (gi = 0; gi < OSC_COUNT; gi = gi + 1) begin : gOsc
            tsrb_osc_counter #(
                .WIDTH    (OSC_WIDTH)
            ) uCounter (
                .mclk     (mclk),
                .porReset (porReset),
                .run      ((gi < OSC_COUNT/2) ? coreOscRun : periphOscRun),
                .tick     (oscTick[gi]),
                .count    (oscCount[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Debug capture registers

    reg [31:0] dbgStatus_reg;
    reg [31:0] dbgPc_reg;
    reg [31:0] dbgSp_reg;
    reg [31:0] dbgStatus_next;

    // Read-only status bits keep their captured value on writes
    always @* begin
        dbgStatus_next = (dbgStatus_reg & ~`TSRB_STAT_WRITE_MASK)
                         | (psWdata & `TSRB_STAT_WRITE_MASK);
    end

    // Entry capture wins over a write landing in the same cycle
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            dbgStatus_reg <= `TSRB_WORD_ZERO;
            dbgPc_reg     <= `TSRB_WORD_ZERO;
            dbgSp_reg     <= `TSRB_WORD_ZERO;
        end else if (debugEntry) begin
            dbgStatus_reg <= threadStatus & `TSRB_STAT_CAPTURE_MASK;
            dbgPc_reg     <= threadPc;
            dbgSp_reg     <= threadSp;
        end else if (wrStrobe && inDebugMode) begin
            if (hitDbgStatus) begin
                dbgStatus_reg <= dbgStatus_next;
            end
            if (hitDbgPc) begin
                dbgPc_reg <= psWdata;
            end
            if (hitDbgSp) begin
                dbgSp_reg <= psWdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux and answer

    reg [31:0] readWord;
    reg        readHit;
    reg        writeOk;
    wire       dbgHit;

    assign dbgHit = hitDbgStatus || hitDbgPc || hitDbgSp;

    // Counts are sampled live; software stops them first for a stable value
    always @* begin
        readWord = `TSRB_WORD_ZERO;
        readHit  = 1'b1;
        case (psNum)
            `TSRB_NUM_BOOT_STATUS:     readWord = bootWord;
            `TSRB_NUM_SECURITY:        readWord = security_reg;
            `TSRB_NUM_OSC_CONTROL:     readWord = {30'h00000000, oscCtrl_reg};
            `TSRB_NUM_OSC_COUNT0:      readWord = {{(32-OSC_WIDTH){1'b0}}, oscCount[0]};
            `TSRB_NUM_OSC_COUNT1:      readWord = {{(32-OSC_WIDTH){1'b0}}, oscCount[1]};
            `TSRB_NUM_OSC_COUNT2:      readWord = {{(32-OSC_WIDTH){1'b0}}, oscCount[2]};
            `TSRB_NUM_OSC_COUNT3:      readWord = {{(32-OSC_WIDTH){1'b0}}, oscCount[3]};
            `TSRB_NUM_MEMORY_CAPACITY: readWord = RAM_BYTES & `TSRB_MEM_CAP_MASK;
            `TSRB_NUM_DBG_STATUS:      readWord = dbgStatus_reg;
            `TSRB_NUM_DBG_PC:          readWord = dbgPc_reg;
            `TSRB_NUM_DBG_SP:          readWord = dbgSp_reg;
            default:                   readHit  = 1'b0;
        endcase
    end

    // Which writes are actually taken
    always @* begin
        writeOk = 1'b0;
        if (hitOscCtrl) begin
            writeOk = 1'b1;
        end else if (hitSecurity) begin
            writeOk = !secLocked;
        end else if (dbgHit) begin
            writeOk = inDebugMode;
        end
    end

    // One-cycle answer for every access
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            psRdata <= `TSRB_WORD_ZERO;
            psAck   <= 1'b0;
            psErr   <= 1'b0;
        end else begin
            psAck <= psValid;
            if (rdStrobe) begin
                psRdata <= readHit ? readWord : `TSRB_WORD_ZERO;
                psErr   <= !readHit;
            end else if (wrStrobe) begin
                psErr   <= !writeOk;
            end else begin
                psErr   <= 1'b0;
            end
        end
    end

endmodule // tsrb_status_bank

/* File: bench/tsrb_status_bank_asserts.sv */
// Port-level checks for the tile status register bank.
`timescale 1ns/1ps
module tsrb_status_bank_asserts (
    input wire        mclk,               // Core clock
    input wire        reset,              // System reset
    input wire        psValid,            // Access strobe
    input wire        psWrite,            // Write select
    input wire [7:0]  psNum,              // Register number
    input wire [31:0] psWdata,            // Write data
    input wire        inDebugMode,        // Debug privilege
    input wire [31:0] psRdata,            // Read data
    input wire        psAck,              // Answer pulse
    input wire        psErr,              // Refusal pulse
    input wire [7:0]  processorNumber,    // Tile number strap
    input wire        otpWordValid,       // OTP load pulse
    input wire [31:0] otpSecurityWord,    // OTP word
    input wire        debugEntry,         // Debugger entry pulse
    input wire [31:0] threadPc,           // Live PC
    input wire        coreOscRun,         // Core osc enable
    input wire        periphOscRun,       // Periph osc enable
    input wire        globalDebugBlocked, // Security bit 14
    input wire        jtagTapBlocked,     // Security bit 0
    input wire        otpMasterLock,      // Security bit 12
    input wire [3:0]  otpSectorLock       // Sector locks
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////
    // Capture then read back; the read must land the cycle after entry
    sequence dbgEntryThenPcRead;
        debugEntry ##1 (psValid && !psWrite && psNum == 8'h11);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    // Answer timing and refusals
    ack_one_cycle_a: assert property (psAck == $past(psValid))
        else $error("ack not one cycle after strobe");
    unmapped_read_a: assert property (psValid && !psWrite && psNum == 8'h04 |=> psErr && psRdata == 32'h0)
        else $error("unmapped read not refused");
    ro_write_a: assert property (psValid && psWrite && psNum == 8'h03 |=> psErr)
        else $error("boot status write accepted");
    dbg_guard_a: assert property (psValid && psWrite && psNum == 8'h11 && !inDebugMode && !debugEntry |=> psErr)
        else $error("debug write outside debug mode accepted");
    // Register contents seen at the outputs
    osc_ctrl_a: assert property (psValid && psWrite && psNum == 8'h06 |=> {coreOscRun, periphOscRun} == $past(psWdata[1:0]) && !psErr)
        else $error("oscillator control not taken");
    boot_num_a: assert property (psValid && !psWrite && psNum == 8'h03 |=> psRdata[23:16] == $past(processorNumber))
        else $error("tile number wrong");
    otp_load_a: assert property (otpWordValid |=> globalDebugBlocked == $past(otpSecurityWord[14]) && jtagTapBlocked == $past(otpSecurityWord[0]))
        else $error("security word not loaded");
    master_lock_a: assert property (otpMasterLock |-> otpSectorLock == 4'hF)
        else $error("master lock misses a sector");
    pc_capture_a: assert property (dbgEntryThenPcRead |=> psRdata == $past(threadPc, 2))
        else $error("saved pc not captured");
endmodule // tsrb_status_bank_asserts

bind tsrb_status_bank tsrb_status_bank_asserts u_chk (.mclk(mclk), .reset(reset), .psValid(psValid),
    .psWrite(psWrite), .psNum(psNum), .psWdata(psWdata), .inDebugMode(inDebugMode), .psRdata(psRdata),
    .psAck(psAck), .psErr(psErr), .processorNumber(processorNumber), .otpWordValid(otpWordValid),
    .otpSecurityWord(otpSecurityWord), .debugEntry(debugEntry), .threadPc(threadPc), .coreOscRun(coreOscRun),
    .periphOscRun(periphOscRun), .globalDebugBlocked(globalDebugBlocked), .jtagTapBlocked(jtagTapBlocked),
    .otpMasterLock(otpMasterLock), .otpSectorLock(otpSectorLock));

/* File: bench/tb_top.sv */
// Self-checking bench for the tile status register bank.
`timescale 1ns/1ps
module tb_top;
    reg         mclk = 0, reset = 1, porReset = 1, psValid = 0, psWrite = 0, inDebugMode = 0;
    reg  [7:0]  psNum = 8'h00;
    reg  [7:0]  procNum = 8'h5A;
    reg  [31:0] psWdata = 32'h0, otpSecurityWord = 32'h0, threadStatus = 32'h0, threadPc = 32'h0, threadSp = 32'h0;
    reg         otpWordValid = 0, debugEntry = 0, bootRam = 0, secBoot = 0;
    reg  [3:0]  oscTick = 4'h0;
    wire [31:0] psRdata;
    wire        psAck, psErr, coreOscRun, periphOscRun, globalDebugBlocked, jtagBootCfgDenied, jtagTapBlocked;
    wire        otpMasterLock, otpRedundancyOn, secureBootFromOtp;
    wire [3:0]  otpSectorLock;
    integer     fails = 0, num_checks = 0, i;
    reg  [31:0] rd;
    reg         er;
    reg  [15:0] base [0:3];

    tsrb_status_bank u_dut (.mclk(mclk), .reset(reset), .porReset(porReset), .psValid(psValid), .psWrite(psWrite),
        .psNum(psNum), .psWdata(psWdata), .inDebugMode(inDebugMode), .psRdata(psRdata), .psAck(psAck),
        .psErr(psErr), .processorNumber(procNum), .clockMultStrapPins(2'h2), .bootFromJtag(1'b1),
        .bootFromRam(bootRam), .otpPollSkip(1'b1), .secondCorePoweredOff(1'b1), .secureBootOverride(secBoot),
        .otpWordValid(otpWordValid), .otpSecurityWord(otpSecurityWord), .oscTick(oscTick),
        .debugEntry(debugEntry), .threadStatus(threadStatus), .threadPc(threadPc), .threadSp(threadSp),
        .coreOscRun(coreOscRun), .periphOscRun(periphOscRun), .globalDebugBlocked(globalDebugBlocked),
        .jtagBootCfgDenied(jtagBootCfgDenied), .jtagTapBlocked(jtagTapBlocked), .otpMasterLock(otpMasterLock),
        .otpSectorLock(otpSectorLock), .otpRedundancyOn(otpRedundancyOn), .secureBootFromOtp(secureBootFromOtp));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, 10 ns period
    initial begin
        forever #5 mclk = ~mclk;
    end
    // Compare and count
    task chk(input [8*12-1:0] name, input [31:0] seen, input [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("BAD %0s exp %h seen %h", name, exp, seen);
        end
    endtask
    // One access; strobe dropped on the edge that takes it, answer read just after
    task acc(input w, input [7:0] n, input [31:0] d);
        @(posedge mclk);
        psValid <= 1'b1;
        psWrite <= w;
        psNum   <= n;
        psWdata <= d;
        @(posedge mclk);
        psValid <= 1'b0;
        #1;
        rd = psRdata;
        er = psErr;
        chk("ack", psAck, 1);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Boot status, RAM size, unmapped and read-only places
    task t_boot;
        acc(0, 8'h03, 0);
        chk("boot", rd, 32'h005A0036);
        acc(1, 8'h03, 32'hFFFFFFFF);
        chk("bootwr", er, 1);
        acc(0, 8'h03, 0);
        chk("bootkeep", rd, 32'h005A0036);
        acc(0, 8'h0C, 0);
        chk("ram", rd, 32'h00040000);
        acc(0, 8'h04, 0);
        chk("unmap", {rd[30:0], er}, 32'h1);
    endtask
    // Security word: software write, OTP load, then locked write
    task t_sec;
        acc(1, 8'h05, 32'h00001011);
        acc(0, 8'h05, 0);
        chk("secwr", rd, 32'h00001011);
        chk("secout", {globalDebugBlocked, otpMasterLock, otpSectorLock, jtagBootCfgDenied, jtagTapBlocked}, 32'h7F);
        acc(1, 8'h05, 32'h00000A00);
        chk("sector", {otpMasterLock, otpSectorLock}, 32'hA);
        @(posedge mclk) otpWordValid <= 1'b1;
        otpSecurityWord <= 32'hFFFFFFFF;
        @(posedge mclk) otpWordValid <= 1'b0;
        acc(0, 8'h05, 0);
        chk("otp", rd, 32'h80005FB1);
        chk("gdbg", globalDebugBlocked, 1);
        chk("otpmisc", {otpRedundancyOn, secureBootFromOtp}, 32'h3);
        acc(1, 8'h05, 32'h0);
        chk("lockerr", er, 1);
        chk("lockkeep", jtagTapBlocked, 1);
    endtask
    // Read all four counts into base
    task rd_counts;
        for (i = 0; i < 4; i = i + 1) begin
            acc(0, 8'h07 + i[7:0], 0);
            base[i] = rd[15:0];
            chk("cnthi", rd[31:16], 0);
        end
    endtask
    // Run for n ticks under ctrl value c, stop, wait, compare against previous counts
    task osc_run(input [1:0] c, input integer n, input [3:0] inc);
        reg [15:0] prev [0:3];
        for (i = 0; i < 4; i = i + 1) prev[i] = base[i];
        acc(1, 8'h06, {30'h0, c});
        @(posedge mclk) oscTick <= 4'hF;
        repeat (n) @(posedge mclk);
        oscTick <= 4'h0;
        acc(1, 8'h06, 32'h0);
        repeat (10) @(posedge mclk);
        rd_counts;
        for (i = 0; i < 4; i = i + 1) chk("count", base[i], prev[i] + {15'h0, inc[i]} * 16'h3);
    endtask
    task t_osc;
        acc(0, 8'h06, 0);
        chk("ctrlrst", rd, 0);
        rd_counts;
        osc_run(2'h0, 5, 4'h0);
        osc_run(2'h2, 3, 4'h3);
        osc_run(2'h1, 65539, 4'hC);
        // System reset with new straps between oscillator runs; counts must survive it
        @(posedge mclk) reset <= 1'b1;
        procNum <= 8'hA5;
        bootRam <= 1'b1;
        secBoot <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        acc(0, 8'h03, 0);
        chk("bootnew", rd, 32'h00A5013E);
        osc_run(2'h0, 2, 4'h0);
    endtask
    // Debug capture, then guarded writes
    task t_dbg;
        @(posedge mclk);
        threadStatus <= 32'hFFFFFFFF;
        threadPc <= 32'h12345678;
        threadSp <= 32'h9ABCDEF0;
        debugEntry <= 1'b1;
        @(posedge mclk) debugEntry <= 1'b0;
        psValid <= 1'b1;
        psWrite <= 1'b0;
        psNum <= 8'h11;
        @(posedge mclk) psValid <= 1'b0;
        #1 chk("pc", psRdata, 32'h12345678);
        acc(0, 8'h12, 0);
        chk("sp", rd, 32'h9ABCDEF0);
        acc(0, 8'h10, 0);
        chk("ssr", rd, 32'h000007DF);
        acc(1, 8'h10, 32'h0);
        chk("ssrerr", er, 1);
        acc(1, 8'h11, 32'h0);
        chk("pcerr", er, 1);
        acc(0, 8'h11, 0);
        chk("pckeep", rd, 32'h12345678);
        @(posedge mclk) inDebugMode <= 1'b1;
        acc(1, 8'h10, 32'h0);
        acc(0, 8'h10, 0);
        chk("ssrwr", rd, 32'h00000100);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        porReset <= 1'b0;
        repeat (2) @(posedge mclk);
        t_boot;
        t_sec;
        t_osc;
        t_dbg;
        end_sim;
    end
    initial begin
        #900000;
        fails = fails + 1;
        end_sim;
    end
endmodule // tb_top
